// file: src/pci_command_status_regs.sv
// command and status configuration registers with their bus gating
`timescale 1ns/1ps
`default_nettype none
`include "pci_cs_cfg.svh"

// Functional notes
// RQ1: command 15:10, status 3:0 read zero
// RQ2: back-to-back enable zero, never generated
// RQ3: command bit 8 gates SERR driver
// RQ4: stepping control hardwired zero
// RQ5: command bit 6 gates PERR drive
// RQ6: palette snoop bit reads zero
// RQ7: bit 4 picks write-invalidate over write
// RQ8: special cycle bit zero, never claimed
// RQ9: initiate cycles only when bit 2 set
// RQ10: claim memory cycles only when bit 1 set
// RQ11: I/O enable zero, I/O never claimed
// RQ12: command resets to all zeros
// RQ13: any parity error sets status 15
// RQ14: signalled SERR sets status 14
// RQ15: received master abort sets status 13
// RQ16: received target abort sets status 12
// RQ17: signalled target abort sets status 11
// RQ18: DEVSEL timing reads 01b, medium decode
// RQ19: status 8 needs PERR, initiator, enable
// RQ20: status 7, 6, 5 hardwired zero
// RQ21: capabilities bit always reads one
// RQ22: status resets to 0210h
// RQ23: write one clears flag, zero keeps
// RQ24: byte enables split command and status
module pci_command_status_regs
  import pci_cs_pkg::*;
(
  input  wire logic       clk,           // bus clock
  input  wire logic       rstn,          // async reset, active low
  input  wire cfg_req_t   cfg,           // configuration access
  output logic     [31:0] cfg_rdata,     // read data, registered
  output logic            cfg_ack,       // access answered, one cycle
  input  wire bus_event_t ev,            // bus events from datapath
  input  wire logic       mem_hit,       // memory address decoded
  input  wire logic       io_hit,        // I/O address decoded
  input  wire logic       special_hit,   // special cycle on bus
  input  wire logic       init_req,      // datapath wants the bus
  input  wire logic       init_is_write, // requested cycle is a write
  output ctrl_t           ctrl,          // command enables
  output logic            mem_claim,     // claim memory cycle
  output logic            io_claim,      // claim I/O cycle
  output logic            special_claim, // claim special cycle
  output logic            init_start,    // start an initiator cycle
  output logic      [3:0] init_cmd,      // bus command to issue
  output logic            b2b_gen,       // fast back-to-back in use
  output logic      [1:0] devsel_timing, // DEVSEL decode speed
  output logic            serr_o,        // SERR pin output level
  output logic            serr_oe_n,     // SERR drive, active low
  output logic            perr_o,        // PERR pin output level
  output logic            perr_oe_n      // PERR drive, active low
);

  // ****************************************
  // access decode
  // ****************************************
  function automatic logic hit(input logic [7:0] addr);
    return addr[7:2] == `CS_DWORD_OFFSET >> 2;
  endfunction

  logic                    wr_hit;
  logic                    rd_hit;
  logic [15:0]             cmd;
  logic [15:0]             sts;
  logic [15:0]             next_cmd;
  logic [`FLAG_COUNT-1:0]  flags;
  logic [`FLAG_COUNT-1:0]  flag_set;
  logic [`FLAG_COUNT-1:0]  flag_clr;
  logic [15:0]             clr_word;
  logic [15:0]             wmask;

  assign wr_hit = cfg.wr && hit(cfg.addr);
  assign rd_hit = cfg.rd && hit(cfg.addr);

  // ****************************************
  // command register
  // ****************************************
  // RQ24 byte enable lanes
  assign wmask = {{8{cfg.be[1]}}, {8{cfg.be[0]}}} & `CMD_RW_MASK;

  // RQ1 RQ4 RQ6 fixed bits masked
  always_comb begin
    next_cmd = cmd;
    if (wr_hit) begin
      next_cmd = (cmd & ~wmask) | (cfg.wdata[15:0] & wmask);
    end
  end

  // RQ12 zero after reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd <= `CMD_RESET;
    end else begin
      cmd <= next_cmd;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= '0;
    end else begin
      ctrl.system_error_drive_en <= next_cmd[`CMD_SERR_EN_BIT];
      ctrl.parity_response_en    <= next_cmd[`CMD_PERR_EN_BIT];
      ctrl.write_invalidate_en   <= next_cmd[`CMD_MWI_EN_BIT];
      ctrl.initiator_en          <= next_cmd[`CMD_INIT_EN_BIT];
      ctrl.memory_space_en       <= next_cmd[`CMD_MEM_EN_BIT];
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  // flag order: 15,14,13,12,11,8
  // RQ23 clear on one, upper status byte
  assign clr_word = (wr_hit && cfg.be[3]) ? {cfg.wdata[31:24], 8'h00} : 16'h0000;
  assign flag_clr = {clr_word[`STS_PARERR_BIT], clr_word[`STS_SYSERR_BIT],
                     clr_word[`STS_IABORT_BIT], clr_word[`STS_TGT_ABORT_RX_BIT],
                     clr_word[`STS_TGT_ABORT_TX_BIT], clr_word[`STS_INIT_DPAR_BIT]};

  // RQ13 any parity error
  // RQ14 SERR actually driven
  // RQ15 RQ16 RQ17 abort events
  // RQ19 all three conditions
  assign flag_set = {ev.addr_parity_err | ev.data_parity_err,
                     ~serr_oe_n,
                     ev.master_abort,
                     ev.target_abort_rx,
                     ev.target_abort_tx,
                     ev.perr_seen & ev.initiator_active & cmd[`CMD_PERR_EN_BIT]};

  sticky_flags #(
    .WIDTH (`FLAG_COUNT)
  ) u_flags (
    .clk   (clk),
    .rstn  (rstn),
    .set   (flag_set),
    .clr   (flag_clr),
    .flags (flags)
  );

  // RQ18 RQ20 RQ21 RQ22 fixed fields
  assign sts = `STS_FIXED_VALUE
             | {flags[5], flags[4], flags[3], flags[2], flags[1], 2'b00, flags[0], 8'h00};

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata <= '0;
      cfg_ack   <= 1'b0;
    end else begin
      cfg_ack   <= wr_hit | rd_hit;
      cfg_rdata <= rd_hit ? {sts, cmd} : 32'h0000_0000;
    end
  end

  // ****************************************
  // bus gating
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_claim     <= 1'b0;
      io_claim      <= 1'b0;
      special_claim <= 1'b0;
      b2b_gen       <= 1'b0;
      devsel_timing <= `DEVSEL_MEDIUM;
    end else begin
      // RQ10 memory claim gate
      mem_claim     <= mem_hit & cmd[`CMD_MEM_EN_BIT];
      // RQ11 I/O never claimed
      io_claim      <= io_hit & cmd[`CMD_IO_EN_BIT];
      // RQ8 special cycles ignored
      special_claim <= special_hit & cmd[`CMD_SPECIAL_BIT];
      // RQ2 no back-to-back
      b2b_gen       <= cmd[`CMD_B2B_BIT];
      // RQ18 medium decode
      devsel_timing <= `DEVSEL_MEDIUM;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      init_start <= 1'b0;
      init_cmd   <= `BUS_CMD_MEM_READ;
    end else begin
      // RQ9 initiator gate
      init_start <= init_req & cmd[`CMD_INIT_EN_BIT];
      // RQ7 write command choice
      if (!init_is_write) begin
        init_cmd <= `BUS_CMD_MEM_READ;
      end else if (cmd[`CMD_MWI_EN_BIT]) begin
        init_cmd <= `BUS_CMD_MEM_WINV;
      end else begin
        init_cmd <= `BUS_CMD_MEM_WRITE;
      end
    end
  end

  // ****************************************
  // error pins
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serr_o    <= 1'b0;
      serr_oe_n <= 1'b1;
      perr_o    <= 1'b0;
      perr_oe_n <= 1'b1;
    end else begin
      serr_o    <= 1'b0;
      perr_o    <= 1'b0;
      // RQ3 SERR on address parity
      serr_oe_n <= ~(ev.addr_parity_err & cmd[`CMD_SERR_EN_BIT]);
      // RQ5 PERR on data parity
      perr_oe_n <= ~(ev.data_parity_err & cmd[`CMD_PERR_EN_BIT]);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_addr_err_enabled;
    ev.addr_parity_err && cmd[`CMD_SERR_EN_BIT];
  endsequence

  sequence s_serr_then_flag;
    !serr_oe_n ##1 sts[`STS_SYSERR_BIT];
  endsequence

  a_cmd_fixed_zero: assert property (  // RQ1
    (cmd & ~`CMD_RW_MASK) == 16'h0000 && !b2b_gen && !io_claim && !special_claim)
    else $error("fixed command bit not zero");

  a_sts_fixed_bits: assert property (  // RQ20
    (sts & `STS_FIXED_MASK) == `STS_FIXED_VALUE && sts[3:0] == 4'h0 && devsel_timing == `DEVSEL_MEDIUM)
    else $error("fixed status field wrong");

  a_serr_flag_chain: assert property (  // RQ14
    s_addr_err_enabled |=> s_serr_then_flag)
    else $error("SERR or its flag missing");

  a_serr_gated_off: assert property (  // RQ3
    !cmd[`CMD_SERR_EN_BIT] |=> serr_oe_n)
    else $error("SERR driven while disabled");

  a_perr_drive_rule: assert property (  // RQ5
    perr_oe_n == !($past(ev.data_parity_err) && $past(cmd[`CMD_PERR_EN_BIT])))
    else $error("PERR drive mismatch");

  a_parity_flag_set: assert property (  // RQ13
    ev.data_parity_err || ev.addr_parity_err |=> sts[`STS_PARERR_BIT])
    else $error("parity flag not set");

  a_abort_flags_set: assert property (  // RQ15
    ev.master_abort |=> sts[`STS_IABORT_BIT])
    else $error("master abort flag not set");

  a_tgt_abort_rx: assert property (  // RQ16
    ev.target_abort_rx |=> sts[`STS_TGT_ABORT_RX_BIT])
    else $error("received target abort flag not set");

  a_tgt_abort_tx: assert property (  // RQ17
    ev.target_abort_tx |=> sts[`STS_TGT_ABORT_TX_BIT])
    else $error("signalled target abort flag not set");

  a_init_dpar_cause: assert property (  // RQ19
    $rose(sts[`STS_INIT_DPAR_BIT]) |-> $past(ev.perr_seen && ev.initiator_active && cmd[`CMD_PERR_EN_BIT]))
    else $error("data parity flag without cause");

  a_flag_clear_one: assert property (  // RQ23
    wr_hit && cfg.be[3] && cfg.wdata[31] && !ev.addr_parity_err && !ev.data_parity_err
    |=> !sts[`STS_PARERR_BIT])
    else $error("write one did not clear");

  a_byte_lane_keep: assert property (  // RQ24
    wr_hit && cfg.be[1:0] == 2'b00 |=> $stable(cmd))
    else $error("command changed without byte enable");

  a_claim_gating: assert property (  // RQ10
    mem_claim |-> $past(mem_hit && cmd[`CMD_MEM_EN_BIT]))
    else $error("memory claimed while disabled");

  a_init_gating: assert property (  // RQ9
    init_start |-> $past(init_req && cmd[`CMD_INIT_EN_BIT]))
    else $error("initiator start while disabled");

  a_write_cmd_pick: assert property (  // RQ7
    init_is_write |=> init_cmd == ($past(cmd[`CMD_MWI_EN_BIT]) ? `BUS_CMD_MEM_WINV : `BUS_CMD_MEM_WRITE))
    else $error("wrong write command");

  a_read_back_word: assert property (  // RQ22
    rd_hit |=> cfg_ack && cfg_rdata == {$past(sts), $past(cmd)})
    else $error("read data wrong");

endmodule

`default_nettype wire

// file: src/pci_cs_cfg.svh
// offsets, field positions, reset values and codes of the command/status pair
`ifndef PCI_CS_CFG_SVH
`define PCI_CS_CFG_SVH

`define CS_DWORD_OFFSET   8'h04
`define CS_CMD_OFFSET     8'h04
`define CS_STS_OFFSET     8'h06

`define CMD_IO_EN_BIT     0
`define CMD_MEM_EN_BIT    1
`define CMD_INIT_EN_BIT   2
`define CMD_SPECIAL_BIT   3
`define CMD_MWI_EN_BIT    4
`define CMD_SNOOP_BIT     5
`define CMD_PERR_EN_BIT   6
`define CMD_STEP_BIT      7
`define CMD_SERR_EN_BIT   8
`define CMD_B2B_BIT       9

`define STS_CAP_CHAIN_BIT 4
`define STS_INIT_DPAR_BIT 8
`define STS_DEVSEL_LSB    9
`define STS_TGT_ABORT_TX_BIT 11
`define STS_TGT_ABORT_RX_BIT 12
`define STS_IABORT_BIT    13
`define STS_SYSERR_BIT    14
`define STS_PARERR_BIT    15

`define CMD_RESET         16'h0000
`define STS_RESET         16'h0210
`define CMD_RW_MASK       16'h0156
`define STS_FIXED_MASK    16'h06F0
`define STS_FIXED_VALUE   16'h0210
`define DEVSEL_MEDIUM     2'h1
`define FLAG_COUNT        6

`define BUS_CMD_MEM_WRITE 4'h7
`define BUS_CMD_MEM_WINV  4'hF
`define BUS_CMD_MEM_READ  4'h6

`endif

// file: src/pci_cs_pkg.sv
// types shared by the command/status register block
package pci_cs_pkg;

  typedef struct packed {
    logic        wr;     // config write strobe
    logic        rd;     // config read strobe
    logic [7:0]  addr;   // byte offset in config space
    logic [3:0]  be;     // byte enables
    logic [31:0] wdata;  // write data
  } cfg_req_t;

  typedef struct packed {
    logic addr_parity_err;  // address parity error seen
    logic data_parity_err;  // data parity error seen
    logic perr_seen;        // PERR asserted by any agent
    logic initiator_active; // we own the current transaction
    logic master_abort;     // our cycle ended by master abort
    logic target_abort_rx;  // our cycle ended by target abort
    logic target_abort_tx;  // we ended a cycle with target abort
  } bus_event_t;

  typedef struct packed {
    logic system_error_drive_en;
    logic parity_response_en;
    logic write_invalidate_en;
    logic initiator_en;
    logic memory_space_en;
  } ctrl_t;

endpackage

// file: src/sticky_flags.sv
// bank of sticky flags, set by hardware, cleared by write-one
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,   // clock
  input  wire logic             rstn,  // async reset, active low
  input  wire logic [WIDTH-1:0] set,   // hardware set pulses
  input  wire logic [WIDTH-1:0] clr,   // software clear pulses
  output logic      [WIDTH-1:0] flags  // latched flags
);

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clr) | set;
    end
  end

endmodule

`default_nettype wire

// file: bench/bus_agent_model.sv
// far-side bus agents: one-cycle events and decodes on command
`timescale 1ns/1ps
`default_nettype none

module bus_agent_model
  import pci_cs_pkg::*;
(
  input  wire logic       go,            // present one event this cycle
  input  wire logic [3:0] sel,           // which event to present
  output bus_event_t      ev,            // bus events toward device
  output logic            mem_hit,       // memory address decode
  output logic            io_hit,        // I/O address decode
  output logic            special_hit,   // special cycle seen
  output logic            init_req,      // datapath wants the bus
  output logic            init_is_write  // requested cycle is a write
);
  // ****************************************
  // event decode
  // ****************************************
  always_comb begin
    ev = '0;
    mem_hit = 1'b0;
    io_hit = 1'b0;
    special_hit = 1'b0;
    init_req = 1'b0;
    init_is_write = 1'b0;
    if (go) begin
      case (sel)
        4'h0: ev.addr_parity_err = 1'b1;
        4'h1: ev.data_parity_err = 1'b1;
        4'h2: ev = '{perr_seen: 1'b1, initiator_active: 1'b1, default: 1'b0};
        4'h3: ev = '{master_abort: 1'b1, initiator_active: 1'b1, default: 1'b0};
        4'h4: ev = '{target_abort_rx: 1'b1, initiator_active: 1'b1, default: 1'b0};
        4'h5: ev.target_abort_tx = 1'b1;
        4'h6: mem_hit = 1'b1;
        4'h7: io_hit = 1'b1;
        4'h8: special_hit = 1'b1;
        4'h9: {init_req, init_is_write} = 2'h3;
        4'hA: init_req = 1'b1;
        4'hB: ev.perr_seen = 1'b1;
        default: ev = '0;
      endcase
    end
  end
endmodule

`default_nettype wire

// file: bench/pci_command_status_regs_tb_top.sv
// self-checking bench for the command/status register pair
`timescale 1ns/1ps
`default_nettype none

module pci_command_status_regs_tb_top
  import pci_cs_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, go = 1'b0;
  logic [3:0] sel = 4'h0;
  cfg_req_t cfg = '0;
  bus_event_t ev;
  ctrl_t ctrl;
  logic [31:0] cfg_rdata, rd_seen;
  logic [3:0] init_cmd;
  logic [1:0] devsel_timing;
  logic cfg_ack, ack_seen, mem_hit, io_hit, special_hit, init_req, init_is_write;
  logic mem_claim, io_claim, special_claim, init_start, b2b_gen;
  logic serr_o, serr_oe_n, perr_o, perr_oe_n;
  int errors = 0, check_count = 0, cycles = 0;

  always #5 clk = ~clk;

  bus_agent_model agent (.go(go), .sel(sel), .ev(ev), .mem_hit(mem_hit), .io_hit(io_hit),
    .special_hit(special_hit), .init_req(init_req), .init_is_write(init_is_write));

  pci_command_status_regs dut (.clk(clk), .rstn(rstn), .cfg(cfg), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .ev(ev), .mem_hit(mem_hit), .io_hit(io_hit), .special_hit(special_hit),
    .init_req(init_req), .init_is_write(init_is_write), .ctrl(ctrl), .mem_claim(mem_claim),
    .io_claim(io_claim), .special_claim(special_claim), .init_start(init_start),
    .init_cmd(init_cmd), .b2b_gen(b2b_gen), .devsel_timing(devsel_timing), .serr_o(serr_o),
    .serr_oe_n(serr_oe_n), .perr_o(perr_o), .perr_oe_n(perr_oe_n));

  // ****************************************
  // tasks
  // ****************************************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one config access; answer sampled in its single standing cycle
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    cfg = '{wr: w, rd: !w, addr: a, be: b, wdata: d};
    @(negedge clk);
    cfg = '0;
    ack_seen = cfg_ack;
    rd_seen = cfg_rdata;
  endtask

  task automatic rd_chk(input logic [31:0] exp);
    acc(1'b0, 8'h04, 4'hF, 32'h0000_0000);
    chk("ack", 32'h1, {31'h0, ack_seen});
    chk("rdata", exp, rd_seen);
  endtask

  task automatic fire(input logic [3:0] s);
    @(negedge clk);
    go = 1'b1;
    sel = s;
    @(negedge clk);
    go = 1'b0;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      end_sim();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    rd_chk(32'h0210_0000);
    chk("devsel", 32'h1, {30'h0, devsel_timing});
    $display("test reset done");

    acc(1'b1, 8'h04, 4'hF, 32'hFFFF_FFFF);
    chk("wr ack", 32'h1, {31'h0, ack_seen});
    rd_chk(32'h0210_0156);
    chk("ctrl", 32'h1F, {27'h0, ctrl});
    acc(1'b0, 8'h08, 4'hF, 32'h0000_0000);
    chk("stray ack", 32'h0, {31'h0, ack_seen});
    $display("test access done");

    fire(4'h6);
    chk("mem_claim", 32'h1, {31'h0, mem_claim});
    fire(4'h7);
    chk("io_claim", 32'h0, {31'h0, io_claim});
    fire(4'h8);
    chk("special", 32'h0, {31'h0, special_claim});
    chk("b2b", 32'h0, {31'h0, b2b_gen});
    fire(4'h9);
    chk("init_start", 32'h1, {31'h0, init_start});
    chk("init_cmd", 32'hF, {28'h0, init_cmd});
    fire(4'h0);
    chk("serr_oe_n", 32'h0, {31'h0, serr_oe_n});
    chk("serr_o", 32'h0, {31'h0, serr_o});
    fire(4'h1);
    chk("perr_oe_n", 32'h0, {31'h0, perr_oe_n});
    chk("perr_o", 32'h0, {31'h0, perr_o});
    for (int i = 2; i < 6; i++)
      fire(i[3:0]);
    rd_chk(32'hFB10_0156);
    $display("test events done");

    acc(1'b1, 8'h04, 4'h8, 32'h8000_0000);
    rd_chk(32'h7B10_0156);
    acc(1'b1, 8'h04, 4'hF, 32'h7900_0000);
    rd_chk(32'h0210_0000);
    fire(4'h6);
    chk("mem_claim", 32'h0, {31'h0, mem_claim});
    fire(4'h9);
    chk("init_start", 32'h0, {31'h0, init_start});
    fire(4'h0);
    chk("serr_oe_n", 32'h1, {31'h0, serr_oe_n});
    fire(4'h1);
    chk("perr_oe_n", 32'h1, {31'h0, perr_oe_n});
    fire(4'h2);
    rd_chk(32'h8210_0000);
    $display("test disabled done");

    acc(1'b1, 8'h04, 4'h3, 32'h0000_0044);
    fire(4'h9);
    chk("init_cmd", 32'h7, {28'h0, init_cmd});
    fire(4'hA);
    chk("init_cmd", 32'h6, {28'h0, init_cmd});
    fire(4'hB);
    rd_chk(32'h8210_0044);
    $display("test write cmd done");

    @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rd_chk(32'h0210_0000);
    chk("ctrl", 32'h0, {27'h0, ctrl});
    $display("test second reset done");
    end_sim();
  end
endmodule

`default_nettype wire
